/* rsp_pkg.sv */
// Purpose: Shared constants for the return stack pointer unit.
// Assumes: APB register map with 32-bit aligned words.
// Notes: Offsets are byte addresses.
package rsp_pkg;
  localparam int unsigned LEVEL_W      = 5;
  localparam int unsigned DEPTH        = 31;
  localparam int unsigned PC_W         = 21;
  localparam logic [4:0]  LEVEL_TOP    = 5'h1F;
  localparam logic [4:0]  LEVEL_EMPTY  = 5'h00;
  localparam int unsigned FULL_BIT     = 7;
  localparam int unsigned UNDER_BIT    = 6;
  localparam logic [7:0]  LEVEL_RST    = 8'h00;
  localparam logic [11:0] OFF_LEVEL    = 12'h000;
  localparam logic [11:0] OFF_TOP_LOW  = 12'h004;
  localparam logic [11:0] OFF_TOP_HIGH = 12'h008;
  localparam logic [11:0] OFF_TOP_UPR  = 12'h00C;
  localparam logic [11:0] OFF_CONFIG   = 12'h010;
  localparam int unsigned RESET_BIT    = 0;
  localparam logic [4:0]  UPPER_MASK_W = 5'h05;
  localparam logic [7:0]  CONFIG_RST   = 8'h00;
endpackage

/* rsp_unit.sv */
// Purpose: Return address stack with level register, fault flags and fault reset.
// Assumes: Core issues at most one push or pop per cycle; APB master from same clock.
// Notes: Entries live in a local array indexed by the stack level.
// Contract
// - Eight-bit level register, flags, pointer.
// - Full flag set when stack fills.
// - Underflow flag set on underflow.
// - Flags cleared only by software or reset.
// - Top entry readable and writable.
// - Push increments level, stores program counter.
// - Software may overwrite pushed entry bytes.
// - Pop decrements level, discarding top.
// - Push and pop never stall core.
// - Reset enable clear: flag only.
// - Reset enable set: flag and reset at the same edge.
`timescale 1ns/1ps
module rsp_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        push_req,
  input  wire logic        pop_req,
  input  wire logic [20:0] pc_value,
  output logic      [20:0] top_entry,
  output logic             stack_fault_reset
);
  logic [7:0]  level_q;
  logic [7:0]  level_d;
  logic [7:0]  config_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        fault_rst_q;
  logic [20:0] entry_mem [0:rsp_pkg::DEPTH];

  wire logic [4:0] level_bits       = level_q[4:0];
  wire logic       stack_full_flag  = level_q[rsp_pkg::FULL_BIT];
  wire logic       stack_under_flag = level_q[rsp_pkg::UNDER_BIT];
  wire logic       stack_fault_reset_enable = config_q[rsp_pkg::RESET_BIT];

  wire logic access   = psel & penable;
  wire logic rd_setup = psel & ~penable & ~pwrite;
  wire logic wr_en    = access & pwrite;
  wire logic rd_en    = access & ~pwrite;
  wire logic hit_lvl  = (paddr == rsp_pkg::OFF_LEVEL);
  wire logic hit_low  = (paddr == rsp_pkg::OFF_TOP_LOW);
  wire logic hit_high = (paddr == rsp_pkg::OFF_TOP_HIGH);
  wire logic hit_upr  = (paddr == rsp_pkg::OFF_TOP_UPR);
  wire logic hit_cfg  = (paddr == rsp_pkg::OFF_CONFIG);
  wire logic hit_any  = hit_lvl | hit_low | hit_high | hit_upr | hit_cfg;

  wire logic wr_lvl  = wr_en & hit_lvl;
  wire logic wr_low  = wr_en & hit_low;
  wire logic wr_high = wr_en & hit_high;
  wire logic wr_upr  = wr_en & hit_upr;

  // A push at the top level overflows and a pop at level zero underflows.
  wire logic at_top      = (level_bits == rsp_pkg::LEVEL_TOP);
  wire logic at_empty    = (level_bits == rsp_pkg::LEVEL_EMPTY);
  wire logic do_push     = push_req & ~pop_req;
  wire logic do_pop      = pop_req & ~push_req;
  wire logic push_ok     = do_push & ~at_top;
  wire logic pop_ok      = do_pop & ~at_empty;
  wire logic becomes_top = push_ok & (level_bits == (rsp_pkg::LEVEL_TOP - 5'h01));
  wire logic full_event  = becomes_top | (do_push & at_top);
  wire logic under_event = do_pop & at_empty;
  wire logic fault_event = full_event | under_event;

  wire logic [4:0]  next_level  = level_d[4:0];
  wire logic [20:0] top_view    = entry_mem[level_bits];

  // Software write takes effect first; hardware events then set flags so
  // that an event in the clearing cycle is not lost.
  always_comb begin
    level_d = level_q;
    if (wr_lvl) begin
      level_d = {pwdata[7:6], 1'b0, pwdata[4:0]};
    end
    if (push_ok) begin
      level_d[4:0] = level_bits + 5'h01;
    end else if (pop_ok) begin
      level_d[4:0] = level_bits - 5'h01;
    end
    if (full_event) begin
      level_d[rsp_pkg::FULL_BIT] = 1'b1;
    end
    if (under_event) begin
      level_d[rsp_pkg::UNDER_BIT] = 1'b1;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_lvl) begin
      rdata_d = {24'h000000, level_q[7:6], 1'b0, level_q[4:0]};
    end else if (hit_low) begin
      rdata_d = {24'h000000, top_view[7:0]};
    end else if (hit_high) begin
      rdata_d = {24'h000000, top_view[15:8]};
    end else if (hit_upr) begin
      rdata_d = {27'h0000000, top_view[20:16]};
    end else if (hit_cfg) begin
      rdata_d = {24'h000000, config_q};
    end
  end

  // Flags sit outside the fault reset: only presetn or a software write to the level register clears them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= rsp_pkg::LEVEL_RST;
    end else begin
      level_q <= level_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= rsp_pkg::CONFIG_RST;
    end else if (wr_en & hit_cfg) begin
      config_q <= {7'h00, pwdata[rsp_pkg::RESET_BIT]};
    end
  end

  // The flag and the reset request are both registered at the edge that ends the fault cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_rst_q <= 1'b0;
    end else begin
      fault_rst_q <= fault_event & stack_fault_reset_enable;
    end
  end

  // Entry storage clears on reset so the top view is defined at level zero.
  // The push and the software byte writes share one write port, and the
  // push wins when both land together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i <= rsp_pkg::DEPTH; i++) begin
        entry_mem[i] <= 21'h000000;
      end
    end else if (push_ok) begin
      entry_mem[next_level] <= pc_value;
    end else if (wr_low) begin
      entry_mem[level_bits][7:0] <= pwdata[7:0];
    end else if (wr_high) begin
      entry_mem[level_bits][15:8] <= pwdata[7:0];
    end else if (wr_upr) begin
      entry_mem[level_bits][20:16] <= pwdata[4:0];
    end
  end

  // Read data is captured in the setup cycle so that it stands during the
  // access phase, when the master samples it with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata            = rdata_q;
  assign pready            = 1'b1;
  assign pslverr           = access & ~hit_any;
  assign top_entry         = top_view;
  assign stack_fault_reset = fault_rst_q;
endmodule // rsp_unit

/* rsp_unit_assertions.sv */
// Purpose: Port checks for the return stack unit.
// Assumes: One clock. Notes: Bound to every rsp_unit below.
`timescale 1ns/1ps
module rsp_unit_assertions (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic        push_req, pop_req, stack_fault_reset,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [20:0] top_entry
);
  wire acc    = psel && penable;
  wire rd_acc = acc && !pwrite;
  wire quiet  = !push_req && !pop_req && !(acc && pwrite);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_a: assert property (acc |-> pready) else $error("Stall.");
  slverr_a: assert property (pslverr == (acc && paddr != rsp_pkg::OFF_LEVEL
    && paddr != rsp_pkg::OFF_TOP_LOW && paddr != rsp_pkg::OFF_TOP_HIGH
    && paddr != rsp_pkg::OFF_TOP_UPR && paddr != rsp_pkg::OFF_CONFIG))
    else $error("Bad error response.");
  level_read_a: assert property (rd_acc && paddr == rsp_pkg::OFF_LEVEL |->
    prdata[31:8] == 24'h000000 && !prdata[5]) else $error("Spare level bits set.");
  low_view_a: assert property (psel && !penable && !pwrite && paddr == rsp_pkg::OFF_TOP_LOW |=>
    prdata == {24'h000000, $past(top_entry[7:0])}) else $error("Low byte differs.");
  low_write_a: assert property (acc && pwrite && paddr == rsp_pkg::OFF_TOP_LOW
    && !push_req && !pop_req |=> top_entry[7:0] == $past(pwdata[7:0])) else $error("Lost.");
  hold_top_a: assert property (quiet |=> $stable(top_entry)) else $error("Top moved.");
  fault_pulse_a: assert property (stack_fault_reset |=> !stack_fault_reset)
    else $error("Long fault pulse.");
  fault_cause_a: assert property (stack_fault_reset |-> $past(push_req || pop_req))
    else $error("Fault without cause.");
endmodule // rsp_unit_assertions
bind rsp_unit rsp_unit_assertions rsp_unit_assertions_i (.*);

/* rsp_core_model.sv */
// Purpose: Core side model issuing push and pop pulses.
// Assumes: One clock. Notes: The counter value is inverted once a request ends.
`timescale 1ns/1ps
module rsp_core_model (
  output logic             push_req, pop_req,
  output logic      [20:0] pc_value,
  input  wire logic        pclk
);
  initial {push_req, pop_req, pc_value} = 23'h000000;
  task automatic issue(input logic psh, input logic [20:0] pc);
    @(posedge pclk);
    {push_req, pop_req, pc_value} <= {psh, !psh, pc};
    @(posedge pclk);
    {push_req, pop_req, pc_value} <= {2'b00, ~pc};
  endtask
endmodule // rsp_core_model

/* testbench.sv */
// Purpose: Self-checking bench for the return stack unit.
// Assumes: Zero-wait slave. Notes: Read data is taken at the edge that samples pready.
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdata;
  logic [20:0] pc_value, top_entry;
  logic        pready, pslverr, push_req, pop_req, stack_fault_reset;
  int          miscompares = 0, n_checks = 0, cycles = 0, faults = 0;
  rsp_unit rsp_unit_i (.*);
  rsp_core_model rsp_core_model_i (.*);
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (stack_fault_reset === 1'b1) faults++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdata, exp);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(rsp_pkg::OFF_LEVEL, 32'h00000000);
    rd(12'h014, 32'h00000000);
    for (int i = 1; i <= 3; i++) rsp_core_model_i.issue(1'b1, 21'h0ABC00 + 21'(i));
    rd(rsp_pkg::OFF_LEVEL, 32'h00000003);
    rd(rsp_pkg::OFF_TOP_LOW, 32'h00000003);
    rd(rsp_pkg::OFF_TOP_HIGH, 32'h000000BC);
    rd(rsp_pkg::OFF_TOP_UPR, 32'h0000000A);
    apb(1'b1, rsp_pkg::OFF_TOP_LOW, 32'h0000005A);
    apb(1'b1, rsp_pkg::OFF_TOP_UPR, 32'h0000001F);
    @(negedge pclk);
    chk({11'h000, top_entry}, 32'h001FBC5A);
    rsp_core_model_i.issue(1'b0, 21'h000000);
    rd(rsp_pkg::OFF_LEVEL, 32'h00000002);
    chk({11'h000, top_entry}, 32'h000ABC02);
    repeat (3) rsp_core_model_i.issue(1'b0, 21'h000000);
    rd(rsp_pkg::OFF_LEVEL, 32'h00000040);
    chk(faults, 0);
    apb(1'b1, rsp_pkg::OFF_LEVEL, 32'h00000000);
    rd(rsp_pkg::OFF_LEVEL, 32'h00000000);
    apb(1'b1, rsp_pkg::OFF_CONFIG, 32'h00000001);
    rsp_core_model_i.issue(1'b0, 21'h000000);
    rd(rsp_pkg::OFF_LEVEL, 32'h00000040);
    chk(faults, 1);
    apb(1'b1, rsp_pkg::OFF_CONFIG, 32'h00000000);
    apb(1'b1, rsp_pkg::OFF_LEVEL, 32'h00000000);
    for (int i = 1; i <= 32; i++) begin
      rsp_core_model_i.issue(1'b1, 21'(i));
      if (i >= 30) rd(rsp_pkg::OFF_LEVEL, (i < 31) ? 32'h0000001E : 32'h0000009F);
    end
    chk(faults, 1);
    conclude();
  end
endmodule // testbench
